// [verilog/msrb_pkg.sv]
// constants of the upper register bank of the motion sensor
package msrb_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] A_ST_GX = 7'h00;
    localparam logic [6:0] A_ST_GY = 7'h01;
    localparam logic [6:0] A_ST_GZ = 7'h02;
    localparam logic [6:0] A_ST_AX = 7'h0d;
    localparam logic [6:0] A_ST_AY = 7'h0e;
    localparam logic [6:0] A_ST_AZ = 7'h0f;
    localparam logic [6:0] A_FSYNC = 7'h36;
    localparam logic [6:0] A_PIN = 7'h37;
    localparam logic [6:0] A_MASK = 7'h38;
    localparam logic [6:0] A_FLAGS = 7'h3a;
    localparam logic [6:0] A_AXH = 7'h3b;
    localparam logic [6:0] A_AXL = 7'h3c;
    localparam logic [6:0] A_AYH = 7'h3d;
    localparam logic [6:0] A_AYL = 7'h3e;
    localparam logic [6:0] A_AZH = 7'h3f;
    localparam logic [6:0] A_AZL = 7'h40;
    localparam logic [6:0] A_TH = 7'h41;
    localparam logic [6:0] A_TL = 7'h42;
    localparam logic [6:0] A_GXH = 7'h43;
    localparam logic [6:0] A_GXL = 7'h44;
    localparam logic [6:0] A_GYH = 7'h45;
    localparam logic [6:0] A_GYL = 7'h46;
    localparam logic [6:0] A_GZH = 7'h47;
    localparam logic [6:0] A_GZL = 7'h48;
    localparam logic [6:0] A_PATH = 7'h68;
    localparam logic [6:0] A_MOT = 7'h69;
    localparam logic [6:0] A_HOST = 7'h6a;
    localparam logic [6:0] A_PWR1 = 7'h6b;
    localparam logic [6:0] A_PWR2 = 7'h6c;
    localparam logic [6:0] A_QLH = 7'h72;
    localparam logic [6:0] A_QLL = 7'h73;
    localparam logic [6:0] A_QDAT = 7'h74;
    localparam logic [6:0] A_ID = 7'h75;
    localparam logic [6:0] A_XTH = 7'h77;
    localparam logic [6:0] A_XTL = 7'h78;
    localparam logic [6:0] A_YTH = 7'h7a;
    localparam logic [6:0] A_YTL = 7'h7b;
    localparam logic [6:0] A_ZTH = 7'h7d;
    localparam logic [6:0] A_ZTL = 7'h7e;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] PWR1_RST = 8'h40;
    localparam int PWR1_SOFT_RST_BIT = 7;
    localparam int PWR1_SLEEP_BIT = 6;
    localparam int FSYNC_FLAG_BIT = 7;
    localparam int ST_BYTES = 6;
endpackage : msrb_pkg

// [verilog/msrb_pair16.sv]
// one 16-bit measurement shown as a high and a low byte
`timescale 1ns/1ns
module msrb_pair16 (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic clear_i,
    input wire logic [15:0] value_i,
    output logic [7:0] high_o,
    output logic [7:0] low_o
);
    import msrb_pkg::*;
    logic [15:0] held;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held <= {REG_RST, REG_RST};
        end else if (clear_i) begin
            held <= {REG_RST, REG_RST};
        end else if (load_i) begin
            held <= value_i;
        end
    end
    assign high_o = held[15:8];
    assign low_o = held[7:0];
endmodule : msrb_pair16

// [verilog/msrb_flag8.sv]
// sticky event flags, cleared by a read, a new event beats the clear
`timescale 1ns/1ns
module msrb_flag8 (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] set_i,
    input wire logic read_clr_i,
    input wire logic clear_i,
    output logic [7:0] flags_o
);
    import msrb_pkg::*;
    logic [7:0] next_flags;
    assign next_flags = (flags_o & ~{8{read_clr_i | clear_i}}) | set_i;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_o <= REG_RST;
        end else begin
            flags_o <= next_flags;
        end
    end
endmodule : msrb_flag8

// [verilog/msrb_reg_bank.sv]
// upper register bank: control, status, sample bytes, queue port, identity, trims
`timescale 1ns/1ns
module msrb_reg_bank #(
    parameter logic [7:0] IDENTITY_CODE = 8'h5c, // value arbitrary
    parameter int QLEVEL_W = 13
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [msrb_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [msrb_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [msrb_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [8*msrb_pkg::ST_BYTES-1:0] factory_st_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] accel_x_result_i,
    input wire logic [15:0] accel_y_result_i,
    input wire logic [15:0] accel_z_result_i,
    input wire logic [15:0] temperature_i,
    input wire logic [15:0] rate_x_i,
    input wire logic [15:0] rate_y_i,
    input wire logic [15:0] rate_z_i,
    input wire logic frame_sync_event_i,
    input wire logic [7:0] irq_event_i,
    input wire logic [QLEVEL_W-1:0] queue_level_i,
    input wire logic [7:0] queue_rdata_i,
    output logic queue_pop_o,
    output logic queue_push_o,
    output logic [7:0] queue_wdata_o,
    output logic asleep_o,
    output logic [7:0] irq_pin_setup_o,
    output logic [7:0] irq_source_mask_o,
    output logic [7:0] sensor_path_reset_o,
    output logic [7:0] motion_detect_ctrl_o,
    output logic [7:0] host_side_ctrl_o,
    output logic [7:0] power_ctrl_primary_o,
    output logic [7:0] power_ctrl_secondary_o,
    output logic [14:0] accel_x_trim_o,
    output logic [14:0] accel_y_trim_o,
    output logic [14:0] accel_z_trim_o
);
    import msrb_pkg::*;

    logic [7:0] self_test [ST_BYTES];
    logic st_loaded;
    logic soft_rst;
    logic [7:0] ax_h, ax_l, ay_h, ay_l, az_h, az_l, t_h, t_l;
    logic [7:0] gx_h, gx_l, gy_h, gy_l, gz_h, gz_l;
    logic [7:0] fsync_flags, irq_flags;
    logic [7:0] xt_h, xt_l, yt_h, yt_l, zt_h, zt_l;
    logic [7:0] next_rdata;
    logic [15:0] qlevel_wide;

    // sleep only blocks writes outside the pin, mask and power registers
    wire sleep_ok = (reg_addr_i == A_PIN) || (reg_addr_i == A_MASK)
        || (reg_addr_i == A_PWR1) || (reg_addr_i == A_PWR2);
    wire wr_ok = reg_wr_i && (!asleep_o || sleep_ok);
    wire wr_pin = wr_ok && (reg_addr_i == A_PIN);
    wire wr_mask = wr_ok && (reg_addr_i == A_MASK);
    wire wr_path = wr_ok && (reg_addr_i == A_PATH);
    wire wr_mot = wr_ok && (reg_addr_i == A_MOT);
    wire wr_host = wr_ok && (reg_addr_i == A_HOST);
    wire wr_pwr1 = wr_ok && (reg_addr_i == A_PWR1);
    wire wr_pwr2 = wr_ok && (reg_addr_i == A_PWR2);
    wire wr_qdat = wr_ok && (reg_addr_i == A_QDAT);
    wire wr_xth = wr_ok && (reg_addr_i == A_XTH);
    wire wr_xtl = wr_ok && (reg_addr_i == A_XTL);
    wire wr_yth = wr_ok && (reg_addr_i == A_YTH);
    wire wr_ytl = wr_ok && (reg_addr_i == A_YTL);
    wire wr_zth = wr_ok && (reg_addr_i == A_ZTH);
    wire wr_ztl = wr_ok && (reg_addr_i == A_ZTL);
    wire rd_fsync = reg_rd_i && (reg_addr_i == A_FSYNC);
    wire rd_flags = reg_rd_i && (reg_addr_i == A_FLAGS);
    wire rd_qdat = reg_rd_i && (reg_addr_i == A_QDAT);
    // results are only taken while awake
    wire capture = sample_valid_i && !asleep_o;
    wire [7:0] fsync_set = {frame_sync_event_i, 7'h00};
    wire [7:0] irq_set = irq_event_i & 8'he5;

    assign asleep_o = power_ctrl_primary_o[PWR1_SLEEP_BIT];
    assign qlevel_wide = 16'(queue_level_i);
    assign accel_x_trim_o = {xt_h, xt_l[7:1]};
    assign accel_y_trim_o = {yt_h, yt_l[7:1]};
    assign accel_z_trim_o = {zt_h, zt_l[7:1]};

    // factory self-test bytes are caught on the first edge after reset release
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_loaded <= 1'b0;
        end else begin
            st_loaded <= !soft_rst;
        end
    end

    always_ff @(posedge clock_i) begin
        for (int i = 0; i < ST_BYTES; i++) begin
            if (!st_loaded) begin
                self_test[i] <= factory_st_i[8*i +: 8];
            end else if (wr_ok && !asleep_o && (reg_addr_i == st_addr(i))) begin
                self_test[i] <= reg_wdata_i;
            end
        end
    end

    function automatic logic [6:0] st_addr(input int idx);
        logic [6:0] a;
        a = A_ST_GX;
        unique case (idx)
            0: a = A_ST_GX;
            1: a = A_ST_GY;
            2: a = A_ST_GZ;
            3: a = A_ST_AX;
            4: a = A_ST_AY;
            default: a = A_ST_AZ;
        endcase
        return a;
    endfunction : st_addr

    // device reset bit restores the bank registers on the next edge (self-test bytes one edge later, queue port untouched) and clears itself
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_pwr1 && reg_wdata_i[PWR1_SOFT_RST_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_ctrl_primary_o <= PWR1_RST;
            power_ctrl_secondary_o <= REG_RST;
            irq_pin_setup_o <= REG_RST;
            irq_source_mask_o <= REG_RST;
        end else if (soft_rst) begin
            power_ctrl_primary_o <= PWR1_RST;
            power_ctrl_secondary_o <= REG_RST;
            irq_pin_setup_o <= REG_RST;
            irq_source_mask_o <= REG_RST;
        end else begin
            if (wr_pwr1) power_ctrl_primary_o <= reg_wdata_i & 8'h7f;
            if (wr_pwr2) power_ctrl_secondary_o <= reg_wdata_i;
            if (wr_pin) irq_pin_setup_o <= reg_wdata_i & 8'hfc;
            if (wr_mask) irq_source_mask_o <= reg_wdata_i & 8'he5;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sensor_path_reset_o <= REG_RST;
            motion_detect_ctrl_o <= REG_RST;
            host_side_ctrl_o <= REG_RST;
        end else if (soft_rst) begin
            sensor_path_reset_o <= REG_RST;
            motion_detect_ctrl_o <= REG_RST;
            host_side_ctrl_o <= REG_RST;
        end else begin
            if (wr_path) sensor_path_reset_o <= reg_wdata_i;
            if (wr_mot) motion_detect_ctrl_o <= reg_wdata_i;
            if (wr_host) host_side_ctrl_o <= reg_wdata_i;
        end
    end

    // trim low bytes keep bit 0 reserved at zero
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {xt_h, xt_l, yt_h, yt_l, zt_h, zt_l} <= '0;
        end else if (soft_rst) begin
            {xt_h, xt_l, yt_h, yt_l, zt_h, zt_l} <= '0;
        end else begin
            if (wr_xth) xt_h <= reg_wdata_i;
            if (wr_xtl) xt_l <= reg_wdata_i & 8'hfe;
            if (wr_yth) yt_h <= reg_wdata_i;
            if (wr_ytl) yt_l <= reg_wdata_i & 8'hfe;
            if (wr_zth) zt_h <= reg_wdata_i;
            if (wr_ztl) zt_l <= reg_wdata_i & 8'hfe;
        end
    end

    // queue port: a read pops one byte, a write pushes one
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            queue_pop_o <= 1'b0;
            queue_push_o <= 1'b0;
            queue_wdata_o <= REG_RST;
        end else begin
            queue_pop_o <= rd_qdat;
            queue_push_o <= wr_qdat;
            if (wr_qdat) queue_wdata_o <= reg_wdata_i;
        end
    end

    // seven results, each held as one 16-bit value behind a byte pair
    msrb_pair16 u_ax (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_i(capture),
        .clear_i(soft_rst), .value_i(accel_x_result_i), .high_o(ax_h), .low_o(ax_l));
    msrb_pair16 u_ay (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_i(capture),
        .clear_i(soft_rst), .value_i(accel_y_result_i), .high_o(ay_h), .low_o(ay_l));
    msrb_pair16 u_az (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_i(capture),
        .clear_i(soft_rst), .value_i(accel_z_result_i), .high_o(az_h), .low_o(az_l));
    msrb_pair16 u_t (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_i(capture),
        .clear_i(soft_rst), .value_i(temperature_i), .high_o(t_h), .low_o(t_l));
    msrb_pair16 u_gx (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_i(capture),
        .clear_i(soft_rst), .value_i(rate_x_i), .high_o(gx_h), .low_o(gx_l));
    msrb_pair16 u_gy (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_i(capture),
        .clear_i(soft_rst), .value_i(rate_y_i), .high_o(gy_h), .low_o(gy_l));
    msrb_pair16 u_gz (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_i(capture),
        .clear_i(soft_rst), .value_i(rate_z_i), .high_o(gz_h), .low_o(gz_l));

    // status flags: a read clears them, an event in the same cycle wins
    msrb_flag8 u_fsync (.clock_i(clock_i), .rst_n_i(rst_n_i), .set_i(fsync_set),
        .read_clr_i(rd_fsync), .clear_i(soft_rst), .flags_o(fsync_flags));
    msrb_flag8 u_irq (.clock_i(clock_i), .rst_n_i(rst_n_i), .set_i(irq_set),
        .read_clr_i(rd_flags), .clear_i(soft_rst), .flags_o(irq_flags));

    // read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = REG_RST;
        unique case (reg_addr_i)
            A_ST_GX: next_rdata = self_test[0];
            A_ST_GY: next_rdata = self_test[1];
            A_ST_GZ: next_rdata = self_test[2];
            A_ST_AX: next_rdata = self_test[3];
            A_ST_AY: next_rdata = self_test[4];
            A_ST_AZ: next_rdata = self_test[5];
            A_FSYNC: next_rdata = fsync_flags;
            A_PIN: next_rdata = irq_pin_setup_o;
            A_MASK: next_rdata = irq_source_mask_o;
            A_FLAGS: next_rdata = irq_flags;
            A_AXH: next_rdata = ax_h;
            A_AXL: next_rdata = ax_l;
            A_AYH: next_rdata = ay_h;
            A_AYL: next_rdata = ay_l;
            A_AZH: next_rdata = az_h;
            A_AZL: next_rdata = az_l;
            A_TH: next_rdata = t_h;
            A_TL: next_rdata = t_l;
            A_GXH: next_rdata = gx_h;
            A_GXL: next_rdata = gx_l;
            A_GYH: next_rdata = gy_h;
            A_GYL: next_rdata = gy_l;
            A_GZH: next_rdata = gz_h;
            A_GZL: next_rdata = gz_l;
            A_PATH: next_rdata = sensor_path_reset_o;
            A_MOT: next_rdata = motion_detect_ctrl_o;
            A_HOST: next_rdata = host_side_ctrl_o;
            A_PWR1: next_rdata = power_ctrl_primary_o;
            A_PWR2: next_rdata = power_ctrl_secondary_o;
            A_QLH: next_rdata = qlevel_wide[15:8];
            A_QLL: next_rdata = qlevel_wide[7:0];
            A_QDAT: next_rdata = queue_rdata_i;
            A_ID: next_rdata = IDENTITY_CODE;
            A_XTH: next_rdata = xt_h;
            A_XTL: next_rdata = xt_l;
            A_YTH: next_rdata = yt_h;
            A_YTL: next_rdata = yt_l;
            A_ZTH: next_rdata = zt_h;
            A_ZTL: next_rdata = zt_l;
            default: next_rdata = REG_RST;
        endcase
    end

    // the address port is the 7-bit field that follows the read/write bit
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= REG_RST;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) reg_rdata_o <= next_rdata;
        end
    end

    default clocking dcb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_rd_id;
        reg_rd_i && (reg_addr_i == A_ID);
    endsequence
    sequence s_rd_flags_quiet;
        rd_flags && (irq_set == 8'h00);
    endsequence

    power_reset_a: assert property ($rose(rst_n_i) |-> power_ctrl_primary_o == 8'h40)
        else $error("primary power register not 0x40 after reset");
    sleep_at_reset_a: assert property ($rose(rst_n_i) |-> asleep_o)
        else $error("device not asleep after reset");
    sleep_no_capture_a: assert property (sample_valid_i && asleep_o |=> $stable(ax_h))
        else $error("sample captured while asleep");
    sleep_write_lock_a: assert property (reg_wr_i && asleep_o && reg_addr_i == A_HOST
        && !soft_rst |=> $stable(host_side_ctrl_o))
        else $error("write accepted while asleep");
    sleep_write_open_a: assert property (reg_wr_i && asleep_o && reg_addr_i == A_MASK
        && !soft_rst |=> irq_source_mask_o == ($past(reg_wdata_i) & 8'he5))
        else $error("mask write refused while asleep");
    accel_high_a: assert property (capture && !soft_rst
        |=> ax_h == $past(accel_x_result_i[15:8]) && ax_l == $past(accel_x_result_i[7:0]))
        else $error("accel x bytes do not match result");
    pair_bytes_a: assert property (capture && !soft_rst
        |=> {t_h, t_l} == $past(temperature_i))
        else $error("temperature pair split wrongly");
    ident_read_a: assert property (s_rd_id |=> reg_rvalid_o && reg_rdata_o == IDENTITY_CODE)
        else $error("identity register read wrong");
    flags_clear_a: assert property (s_rd_flags_quiet ##1 !rd_flags && irq_set == 8'h00
        |-> irq_flags == 8'h00)
        else $error("event flags not cleared by read");
    set_wins_a: assert property (rd_flags && irq_set[0] |=> irq_flags[0])
        else $error("event lost during clear");
    selftest_load_a: assert property ($rose(rst_n_i) |=> st_loaded
        && self_test[0] == $past(factory_st_i[7:0]))
        else $error("self-test byte not loaded at reset");
    zero_reset_a: assert property ($rose(rst_n_i) |-> irq_flags == 8'h00
        && host_side_ctrl_o == 8'h00 && accel_x_trim_o == 15'h0000)
        else $error("register not zero after reset");

    // soft reset: registers restored on the next edge, self-test bytes one edge later
    sequence s_soft_reload;
        soft_rst ##2 1'b1;
    endsequence

    soft_reset_a: assert property (soft_rst |=> power_ctrl_primary_o == PWR1_RST
        && host_side_ctrl_o == REG_RST && irq_source_mask_o == REG_RST)
        else $error("soft reset left a register set");
    selftest_reload_a: assert property (s_soft_reload |-> self_test[5]
        == $past(factory_st_i[47:40]))
        else $error("self-test bytes not reloaded after soft reset");
    fsync_clear_a: assert property (rd_fsync && !frame_sync_event_i
        |=> fsync_flags == REG_RST)
        else $error("frame sync flag not cleared by read");
    flag_answer_a: assert property (rd_flags |=> reg_rdata_o == $past(irq_flags))
        else $error("event flags answered after the clear");
    sleep_pwr2_open_a: assert property (reg_wr_i && asleep_o && reg_addr_i == A_PWR2
        && !soft_rst |=> power_ctrl_secondary_o == $past(reg_wdata_i))
        else $error("secondary power write refused while asleep");
    trim_write_a: assert property (wr_xth && !soft_rst |=> xt_h == $past(reg_wdata_i))
        else $error("trim high byte not written");
    // read port and queue handshake
    queue_pop_a: assert property (rd_qdat
        |=> queue_pop_o && reg_rdata_o == $past(queue_rdata_i))
        else $error("queue read did not pop a byte");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
endmodule : msrb_reg_bank

// [test/msrb_host_model.sv]
// host side model: issues one register access per call on the strobe port
`timescale 1ns/1ns
module msrb_host_model (
    input wire logic clock_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [6:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    initial begin
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_addr_o = 7'h55;
        reg_wdata_o = 8'haa;
    end

    // first byte: top bit picks read (1) or write (0), low seven bits the address
    task automatic xfer(input int idle, input logic [7:0] cmd, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic rvalid);
        repeat (idle) @(posedge clock_i);
        @(posedge clock_i);
        reg_rd_o <= cmd[7];
        reg_wr_o <= ~cmd[7];
        reg_addr_o <= cmd[6:0];
        reg_wdata_o <= wdata;
        @(posedge clock_i);
        reg_rd_o <= 1'b0;
        reg_wr_o <= 1'b0;
        // released lines show the inverse, never the last value
        reg_addr_o <= ~cmd[6:0];
        reg_wdata_o <= ~wdata;
        #1;
        rdata = reg_rdata_i;
        rvalid = reg_rvalid_i;
    endtask : xfer
endmodule : msrb_host_model

// [test/msrb_reg_bank_tb.sv]
// self-checking bench of the upper register bank
`timescale 1ns/1ns
module msrb_reg_bank_tb;
    import msrb_pkg::*;
    localparam logic [7:0] ID_CODE = 8'h3c; // value arbitrary
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } msrb_row_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic reg_rd, reg_wr, reg_rvalid, queue_pop, queue_push, asleep;
    logic sample_valid = 1'b0;
    logic fsync_ev = 1'b0;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, queue_wdata, pin_setup, src_mask, pwr1, pwr2;
    logic [7:0] irq_ev = 8'h00;
    logic [7:0] queue_rdata = 8'h00;
    logic [12:0] queue_level = 13'h0000;
    logic [47:0] factory_st = 48'h1122_3344_5566;
    logic [15:0] res [7] = '{default: 16'h0000};
    logic [14:0] x_trim;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int gap = 0;
    msrb_row_s rows [27] = '{
        '{1'b0, A_PWR1, 8'h00, PWR1_RST}, '{1'b0, A_ID, 8'h00, ID_CODE},
        '{1'b0, A_ST_GX, 8'h00, 8'h66}, '{1'b0, A_ST_AZ, 8'h00, 8'h11},
        '{1'b0, A_FSYNC, 8'h00, 8'h00}, '{1'b0, A_FLAGS, 8'h00, 8'h00},
        '{1'b0, A_AXH, 8'h00, 8'h00}, '{1'b0, A_GZL, 8'h00, 8'h00},
        '{1'b0, A_QLL, 8'h00, 8'h00}, '{1'b0, A_ZTL, 8'h00, 8'h00},
        '{1'b0, 7'h50, 8'h00, 8'h00}, '{1'b1, A_HOST, 8'hff, 8'h00},
        '{1'b1, A_XTH, 8'hff, 8'h00}, '{1'b1, A_PIN, 8'hff, 8'hfc},
        '{1'b1, A_MASK, 8'hff, 8'he5}, '{1'b1, A_PWR2, 8'ha5, 8'ha5},
        '{1'b1, A_PWR1, 8'h00, 8'h00}, '{1'b1, A_HOST, 8'h5a, 8'h5a},
        '{1'b1, A_XTH, 8'h81, 8'h81}, '{1'b1, A_XTL, 8'hff, 8'hfe},
        '{1'b1, A_PATH, 8'h0f, 8'h0f}, '{1'b1, A_MOT, 8'hc0, 8'hc0},
        '{1'b1, A_YTH, 8'h3c, 8'h3c}, '{1'b1, A_ZTL, 8'h55, 8'h54},
        '{1'b1, A_AXH, 8'h12, 8'h00}, '{1'b1, A_ST_GX, 8'h77, 8'h77},
        '{1'b1, 7'h50, 8'h33, 8'h00}};

    always #25 clock = ~clock;

    msrb_host_model i_host (.clock_i(clock), .reg_rdata_i(reg_rdata),
        .reg_rvalid_i(reg_rvalid), .reg_rd_o(reg_rd), .reg_wr_o(reg_wr),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

    msrb_reg_bank #(.IDENTITY_CODE(ID_CODE), .QLEVEL_W(13)) i_dut (
        .clock_i(clock), .rst_n_i(rst_n), .reg_rd_i(reg_rd), .reg_wr_i(reg_wr),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .reg_rvalid_o(reg_rvalid), .factory_st_i(factory_st),
        .sample_valid_i(sample_valid), .accel_x_result_i(res[0]),
        .accel_y_result_i(res[1]), .accel_z_result_i(res[2]), .temperature_i(res[3]),
        .rate_x_i(res[4]), .rate_y_i(res[5]), .rate_z_i(res[6]),
        .frame_sync_event_i(fsync_ev), .irq_event_i(irq_ev), .queue_level_i(queue_level),
        .queue_rdata_i(queue_rdata), .queue_pop_o(queue_pop), .queue_push_o(queue_push),
        .queue_wdata_o(queue_wdata), .asleep_o(asleep), .irq_pin_setup_o(pin_setup),
        .irq_source_mask_o(src_mask), .sensor_path_reset_o(), .motion_detect_ctrl_o(),
        .host_side_ctrl_o(), .power_ctrl_primary_o(pwr1), .power_ctrl_secondary_o(pwr2),
        .accel_x_trim_o(x_trim), .accel_y_trim_o(), .accel_z_trim_o());

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : check

    task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_host.xfer(gap, {1'b1, a}, 8'h00, d, v);
        check("read valid", 16'h0001, 16'(v));
        check($sformatf("register %h", a), 16'(exp), 16'(d));
    endtask : rd_reg

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] data);
        logic [7:0] d;
        logic v;
        i_host.xfer(gap, {1'b0, a}, data, d, v);
        check("no read valid on write", 16'h0000, 16'(v));
    endtask : wr_reg

    // sensor and event pulses, one cycle wide
    task automatic pulse(input logic smp, input logic [7:0] ev, input logic fs);
        @(posedge clock);
        sample_valid <= smp;
        irq_ev <= ev;
        fsync_ev <= fs;
        @(posedge clock);
        sample_valid <= 1'b0;
        irq_ev <= 8'h00;
        fsync_ev <= 1'b0;
    endtask : pulse

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(posedge clock);
        #1;
        check("power primary in reset", 16'(PWR1_RST), 16'(pwr1));
        check("asleep in reset", 16'h0001, 16'(asleep));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        foreach (rows[i]) begin
            if (rows[i].wr) wr_reg(rows[i].addr, rows[i].data);
            rd_reg(rows[i].addr, rows[i].exp);
        end
        check("pin setup", 16'h00fc, 16'(pin_setup));
        check("mask", 16'h00e5, 16'(src_mask));
        check("power secondary", 16'h00a5, 16'(pwr2));
        check("x trim", {1'b0, 8'h81, 7'h7f}, {1'b0, x_trim});
        @(posedge clock);
        foreach (res[i]) res[i] <= 16'h1357 + 16'h2222 * 16'(i);
        queue_level <= 13'h1abc;
        pulse(1'b1, 8'h00, 1'b0);
        gap = 2;
        for (int i = 0; i < 14; i++) begin
            rd_reg(7'(A_AXH + i), i[0] ? res[i / 2][7:0] : res[i / 2][15:8]);
        end
        gap = 0;
        rd_reg(A_QLH, 8'h1a);
        rd_reg(A_QLL, 8'hbc);
        pulse(1'b0, 8'hff, 1'b1);
        rd_reg(A_FLAGS, 8'he5);
        rd_reg(A_FLAGS, 8'h00);
        rd_reg(A_FSYNC, 8'h80);
        rd_reg(A_FSYNC, 8'h00);
        // event in the same cycle as the clearing read: the set wins
        fork
            pulse(1'b0, 8'h01, 1'b0);
            rd_reg(A_FLAGS, 8'h00);
        join
        rd_reg(A_FLAGS, 8'h01);
        rd_reg(A_FLAGS, 8'h00);
        @(posedge clock);
        queue_rdata <= 8'hc3;
        rd_reg(A_QDAT, 8'hc3);
        check("queue pop", 16'h0001, 16'(queue_pop));
        wr_reg(A_QDAT, 8'h99);
        check("queue push", 16'h0001, 16'(queue_push));
        check("queue write data", 16'h0099, 16'(queue_wdata));
        @(posedge clock);
        factory_st <= 48'h0102_0304_05a7;
        wr_reg(A_PWR1, 8'h80);
        repeat (3) @(posedge clock);
        #1;
        check("asleep after soft reset", 16'h0001, 16'(asleep));
        rd_reg(A_PWR1, PWR1_RST);
        rd_reg(A_HOST, 8'h00);
        rd_reg(A_ST_GX, 8'ha7);
        rd_reg(A_AXH, 8'h00);
        pulse(1'b1, 8'h00, 1'b0);
        rd_reg(A_AXH, 8'h00);
        wr_reg(A_PIN, 8'hff);
        @(posedge clock);
        rst_n <= 1'b0;
        @(negedge clock);
        check("power primary in second reset", 16'(PWR1_RST), 16'(pwr1));
        check("pin setup in second reset", 16'h0000, 16'(pin_setup));
        @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd_reg(A_PWR1, PWR1_RST);
        report_and_stop();
    end
endmodule : msrb_reg_bank_tb
